/* File: include/sar_pkg.sv */
package sar_pkg;
    // Period of the host logic clock in picoseconds.
    localparam int CLK_PERIOD_PS = 50000;
    // Least quiet time of the shift clock after the strobe falls, in ps.
    localparam int QUIET_PS      = 9500;
    // Least delay from the last shift clock activity to the strobe rising, in ps.
    localparam int RISE_GAP_PS   = 19100;
    // Least shift clock period, in ps.
    localparam int SCK_PERIOD_PS = 9400;
    // Derived cycle counts; least times round up and none falls below one.
    localparam int QUIET_CYC_RAW = (QUIET_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int QUIET_CYC     = (QUIET_CYC_RAW < 1) ? 1 : QUIET_CYC_RAW;
    localparam int GAP_CYC_RAW   = (RISE_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GAP_CYC       = (GAP_CYC_RAW < 1) ? 1 : GAP_CYC_RAW;
    localparam int HALF_CYC_RAW  = (SCK_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HALF_CYC      = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
    // Depth of the host's data pin synchroniser.
    localparam int SYNC_STAGES   = 3;
    // A level shown on the data pin is usable one edge after it clears the
    // synchroniser, so the quiet time and the low phase last at least its depth.
    localparam int SETTLE_CYC    = SYNC_STAGES;
    localparam int QUIET_HOLD    = (QUIET_CYC < SETTLE_CYC) ? SETTLE_CYC : QUIET_CYC;
    localparam int LOW_HOLD      = (HALF_CYC < SETTLE_CYC) ? SETTLE_CYC : HALF_CYC;
    // Result word width.
    localparam int WORD_BITS     = 16;
    // Width of the small timing counter.
    localparam int CNT_W         = 8;
    // Signalling modes selected by the mode pin.
    localparam logic [1:0] MODE_CMOS   = 2'h0;
    localparam logic [1:0] MODE_LVDS   = 2'h1;
    localparam logic [1:0] MODE_LPLVDS = 2'h2;
    // Host sequencer states.
    typedef enum logic [2:0] {
        SAR_IDLE  = 3'b000,
        SAR_QUIET = 3'b001,
        SAR_HIGH  = 3'b010,
        SAR_LOW   = 3'b011,
        SAR_GAP   = 3'b100
    } sar_state_t;
endpackage : sar_pkg

/* File: rtl/sar_host.sv */
// Overview of operation
// R1 - Strobe high keeps the device sampling.
// R2 - Strobe falling edge starts conversion and readout.
// R3 - Device shifts result MSB first on falling edges.
// R4 - Keep shift clock quiet 9.5 ns after fall.
// R5 - Wait 19.1 ns after clocking before strobe rises.
// R6 - Device releases data line within 5 ns.
// R7 - First bit valid within 5 ns after fall.
// R8 - Shift clock period at least 9.4 ns.
// R9 - Mode pin selects CMOS, LVDS or low-power LVDS.
// R10 - Strobe behaves the same in every mode.
// R11 - CMOS mode uses only the positive pins.
// R12 - LVDS modes use differential clock and data.
// R13 - Shifted word is the previous conversion result.
// R14 - Result words are two's complement.
// R15 - Conversion steps advance with shift clock pulses.
// R16 - Strobe low, sixteen falling edges, then strobe high.
`timescale 1ns/100ps
`default_nettype none
module sar_host
    import sar_pkg::*;
#(
    parameter int WORD_W = sar_pkg::WORD_BITS
) (
    // Clock and reset.
    input  wire logic                  clock,
    input  wire logic                  resetn,
    // Request and result.
    input  wire logic                  start,
    input  wire logic [1:0]            io_mode,
    output logic                       busy,
    output logic                       result_valid,
    output logic signed [WORD_W-1:0]   result,
    // Device pins.
    output logic                       convert_strobe_n,
    output logic                       shift_clk_pos,
    output logic                       shift_clk_neg,
    input  wire logic                  serial_out_pos,
    input  wire logic                  serial_out_neg
);
    import sar_pkg::*;

    // Sequencer, timing and capture registers.
    sar_state_t              state_reg, state_next;  // Sequencer state.
    logic [CNT_W-1:0]        cnt_reg;                // Timing counter.
    logic [4:0]              bits_reg;               // Falling edges issued.
    logic [WORD_W-1:0]       shift_reg;              // Capture register.
    logic                    strobe_reg;             // Strobe pin drive.
    logic                    sck_reg;                // Shift clock drive.
    logic                    valid_reg;              // Result pulse.
    logic [2:0]              din_sync;               // Data pin synchroniser.
    logic                    data_hold_reg;          // Last settled data level.

    // Timing counter expiry and the falling edge of the shift clock.
    wire cnt_done  = (cnt_reg == '0);
    wire fall_now  = (state_reg == SAR_HIGH) && cnt_done;
    wire last_bit  = (bits_reg == 5'(WORD_W - 1));
    // In LVDS modes the pair is resolved as positive over negative; CMOS uses only positive.
    wire data_pin  = (io_mode == MODE_CMOS) ? serial_out_pos
                                            : (serial_out_pos & ~serial_out_neg); // see R11 see R12
    // The third stage is only trusted once the second agrees with it; while they
    // differ the pin is mid-change and the last settled level is used instead.
    wire data_agree = (din_sync[1] == din_sync[2]);
    wire data_bit   = data_agree ? din_sync[2] : data_hold_reg;
    // Every bit of the word has been clocked once the count reaches the width;
    // testing for the last bit here instead would end the read one falling edge short.
    wire all_sent   = (bits_reg == 5'(WORD_W));

    // Next-state decode of the read sequence.
    // A start is only looked at while idle; one that arrives during a read is
    // dropped with no indication, so a caller must wait for busy to fall.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SAR_IDLE:  if (start) state_next = SAR_QUIET;              // see R16
            SAR_QUIET: if (cnt_done) state_next = SAR_HIGH;            // see R4
            SAR_HIGH:  if (cnt_done) state_next = SAR_LOW;
            SAR_LOW:   if (cnt_done) state_next = all_sent ? SAR_GAP : SAR_HIGH;
            SAR_GAP:   if (cnt_done) state_next = SAR_IDLE;            // see R5
            default:   state_next = SAR_IDLE;
        endcase
    end

    // Sequencer and counter; every stage waits at least its least time.
    // The quiet time and the low phase are held for at least as many cycles as
    // the data synchroniser is deep. A bit that the device shows after an edge
    // is then settled in the third stage before the next falling edge samples
    // it, at the price of a slower shift clock than the pins would allow.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg <= SAR_IDLE;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg || (state_reg != SAR_IDLE && cnt_done)) begin
                case (state_next)
                    SAR_QUIET: cnt_reg <= CNT_W'(QUIET_HOLD - 1);     // see R4
                    // The low phase is stretched so that the next bit has settled.
                    SAR_LOW:   cnt_reg <= CNT_W'(LOW_HOLD - 1);       // see R8
                    SAR_GAP:   cnt_reg <= CNT_W'(GAP_CYC - 1);        // see R5
                    default:   cnt_reg <= CNT_W'(HALF_CYC - 1);       // see R8
                endcase
            end else if (!cnt_done) begin
                cnt_reg <= cnt_reg - CNT_W'(1);
            end
        end
    end

    // Pin drive: strobe low for the whole read, clock high then low per bit.
    // Strobe and positive clock are registered and change only on the clock edge; the negative clock leg also follows the mode pin.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            strobe_reg <= 1'b1;                                        // see R1
            sck_reg    <= 1'b0;
        end else begin
            strobe_reg <= (state_next == SAR_IDLE);                    // see R2 see R10
            sck_reg    <= (state_next == SAR_HIGH);                    // see R15
        end
    end

    // The data pin is asynchronous to this clock, so it passes three stages.
    // The settled level is kept alongside, so a pin caught between levels
    // never reaches the capture register.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            din_sync      <= 3'h0;
            data_hold_reg <= 1'b0;
        end else begin
            din_sync      <= {din_sync[1:0], data_pin};
            data_hold_reg <= data_bit;
        end
    end

    // Bits are taken at each falling edge, MSB first; the bit sampled there
    // was set up by the previous edge or by the strobe fall.
    // The bit count is cleared while idle, so no stale count reaches the next read.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            bits_reg  <= 5'h0;
            shift_reg <= '0;
            valid_reg <= 1'b0;
            result    <= '0;
        end else begin
            valid_reg <= 1'b0;
            if (state_reg == SAR_IDLE) begin
                bits_reg <= 5'h0;
            end
            if (fall_now) begin
                shift_reg <= {shift_reg[WORD_W-2:0], data_bit};        // see R3
                bits_reg  <= bits_reg + 5'h1;
                if (last_bit) begin
                    // The word belongs to the previous conversion.
                    result    <= $signed({shift_reg[WORD_W-2:0], data_bit}); // see R13 see R14
                    valid_reg <= 1'b1;
                end
            end
        end
    end

    assign convert_strobe_n = strobe_reg;
    assign shift_clk_pos    = sck_reg;
    // The negative clock leg is only meaningful in LVDS modes; held low in CMOS.
    assign shift_clk_neg    = (io_mode == MODE_CMOS) ? 1'b0 : ~sck_reg; // see R9 see R11
    // Busy is decoded from the state, so a caller sees it drop in the idle cycle.
    assign busy             = (state_reg != SAR_IDLE);
    assign result_valid     = valid_reg;

    // Checks on the pins that this block drives and on its bit count; each ties to a host-side rule.
    // Strobe must stay low throughout clocking.
    AST_STROBE_LOW_WHILE_CLOCKING: assert property (@(posedge clock) disable iff (!resetn)
        shift_clk_pos |-> !convert_strobe_n) else $error("clock while strobe high"); // see R16
    // Shift clock stays quiet just after the strobe falls.
    AST_QUIET_AFTER_FALL: assert property (@(posedge clock) disable iff (!resetn)
        $fell(convert_strobe_n) |-> !shift_clk_pos) else $error("clock too soon"); // see R4
    // Strobe does not rise right after a clock pulse.
    AST_GAP_BEFORE_RISE: assert property (@(posedge clock) disable iff (!resetn)
        $rose(convert_strobe_n) |-> !$past(shift_clk_pos)) else $error("rise too soon"); // see R5
    // Clock high lasts at least one cycle and ends within bounds.
    AST_SCK_HIGH_BOUNDED: assert property (@(posedge clock) disable iff (!resetn)
        $rose(shift_clk_pos) |-> ##[1:4] !shift_clk_pos) else $error("clock high stuck"); // see R8
    // A read completes with a result pulse within bounded time.
    AST_READ_COMPLETES: assert property (@(posedge clock) disable iff (!resetn)
        $fell(convert_strobe_n) |-> ##[32:80] result_valid) else $error("no result"); // see R16
    // Result pulse comes only while the strobe is still low.
    AST_VALID_IN_READ: assert property (@(posedge clock) disable iff (!resetn)
        result_valid |-> !convert_strobe_n) else $error("result outside read"); // see R13
    // Negative clock leg is idle in CMOS mode.
    AST_CMOS_NEG_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        (io_mode == MODE_CMOS) |-> !shift_clk_neg) else $error("neg leg active"); // see R11
    // Strobe is high whenever the sequencer has been idle for two cycles running.
    AST_IDLE_SAMPLING: assert property (@(posedge clock) disable iff (!resetn)
        (!busy && !$past(busy)) |-> convert_strobe_n) else $error("strobe low idle"); // see R1
    // No clock pulse is issued while waiting before the strobe rises.
    AST_GAP_NO_CLOCK: assert property (@(posedge clock) disable iff (!resetn) // see R5
        (state_reg == SAR_GAP) |-> !shift_clk_pos) else $error("clock during gap");
    // After each falling edge the clock stays low while the next bit settles.
    AST_LOW_STRETCHED: assert property (@(posedge clock) disable iff (!resetn) // see R8
        $fell(shift_clk_pos) |-> !shift_clk_pos [*3]) else $error("low phase short");
    // After the strobe falls the clock stays quiet until the first bit settles.
    AST_FIRST_FALL_SETTLED: assert property (@(posedge clock) disable iff (!resetn) // see R4
        $fell(convert_strobe_n) |-> !shift_clk_pos [*3]) else $error("first edge early");
    // A word is handed up only once all of its bits have been clocked.
    AST_VALID_AT_LAST_BIT: assert property (@(posedge clock) disable iff (!resetn) // see R13
        result_valid |-> (bits_reg == 5'(WORD_W))) else $error("word handed up early");
    // The count of falling edges never passes the word width.
    AST_BIT_COUNT_BOUNDED: assert property (@(posedge clock) disable iff (!resetn) // see R16
        bits_reg <= 5'(WORD_W)) else $error("too many edges");
    // A start during a read does not disturb the strobe.
    AST_START_IGNORED_BUSY: assert property (@(posedge clock) disable iff (!resetn) // see R16
        (busy && start && state_reg != SAR_GAP) |=> !convert_strobe_n) else $error("start taken");
    // Every read ends and busy falls within a bounded time.
    AST_BUSY_BOUNDED: assert property (@(posedge clock) disable iff (!resetn) // see R16
        $rose(busy) |-> ##[1:100] !busy) else $error("read never ends");
endmodule : sar_host
`default_nettype wire

/* File: dv/sar_adc_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Behavioural converter: latches a code at each strobe fall and shifts the previous one out.
module sar_adc_model
    import sar_pkg::*;
(
    // Pins driven by the host.
    input  wire logic                        convert_strobe_n,
    input  wire logic                        shift_clk_pos,
    input  wire logic [1:0]                  io_mode,
    // Value the analog input would convert to.
    input  wire logic signed [WORD_BITS-1:0] analog_code,
    // Data pins back to the host.
    output logic                             serial_out_pos,
    output logic                             serial_out_neg
);
    logic signed [WORD_BITS-1:0] held_reg; // Two's complement word on the wire.
    logic signed [WORD_BITS-1:0] conv_reg; // Word under conversion.
    int      bit_idx, steps, viol;         // Bit pointer, steps taken, host slips.
    realtime t_fall, t_sck, t_neg;         // Times of the last strobe fall and clock edges.
    // Drive one bit; a negative pin left open in single-ended mode just wanders.
    task automatic put(input logic b);
        serial_out_pos = b;
        serial_out_neg = (io_mode == MODE_CMOS) ? ~serial_out_neg : ~b;
    endtask : put
    initial begin
        {held_reg, conv_reg, viol, serial_out_pos, serial_out_neg} = '0;
        steps = 16;
        t_sck = -100.0;
        t_neg = -100.0;
    end
    // Strobe fall ends sampling and shows the old MSB within 5 ns.
    always @(negedge convert_strobe_n) begin
        held_reg = conv_reg;
        conv_reg = analog_code;
        bit_idx = 15;
        steps = 0;
        t_fall = $realtime;
        #2 put(held_reg[bit_idx]);
    end
    // Each falling clock edge moves on one approximation step, and one bit until bit 0 is reached.
    always @(negedge shift_clk_pos) if (!convert_strobe_n) begin
        if ($realtime - t_neg < 9.4) viol++;
        t_neg = $realtime;
        steps = steps + 1;
        if (bit_idx > 0) bit_idx--;
        #4 put(held_reg[bit_idx]);
    end
    // The clock must stay quiet just after the strobe falls.
    always @(posedge shift_clk_pos) if (!convert_strobe_n && $realtime - t_fall < 9.5) viol++;
    always @(shift_clk_pos) if (!convert_strobe_n) t_sck = $realtime;
    // Strobe rise: gap and count are checked, then the line lets go within 5 ns.
    always @(posedge convert_strobe_n) begin
        if ($realtime - t_sck < 19.1 || steps != 16) viol++;
        #3 put(~serial_out_pos);
    end
endmodule : sar_adc_model
`default_nettype wire

/* File: dv/test_sar_host.sv */
`timescale 1ns/100ps
`default_nettype none
module test_sar_host;
    import sar_pkg::*;
    logic                        clock, resetn, start, busy, result_valid;
    logic                        convert_strobe_n, shift_clk_pos, shift_clk_neg;
    logic                        serial_out_pos, serial_out_neg;
    logic [1:0]                  io_mode;
    logic signed [WORD_BITS-1:0] result, analog_code, prev_code;
    logic signed [WORD_BITS-1:0] exp_q[$];   // Words the host should hand up, oldest first.
    int                          n_mismatch = 0, checks_done = 0;
    sar_host DUT (.clock(clock), .resetn(resetn), .start(start), .io_mode(io_mode),
        .busy(busy), .result_valid(result_valid), .result(result),
        .convert_strobe_n(convert_strobe_n), .shift_clk_pos(shift_clk_pos),
        .shift_clk_neg(shift_clk_neg), .serial_out_pos(serial_out_pos),
        .serial_out_neg(serial_out_neg));
    sar_adc_model model (.convert_strobe_n(convert_strobe_n), .shift_clk_pos(shift_clk_pos),
        .io_mode(io_mode), .analog_code(analog_code), .serial_out_pos(serial_out_pos),
        .serial_out_neg(serial_out_neg));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        checks_done++;
        if (got !== want) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check
    task automatic results;
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // One read; the word that comes back is the one converted in the read before.
    task automatic read(input logic [1:0] m, input logic [15:0] c, input bit poke);
        {io_mode, analog_code, start} = {m, c, 1'b1};
        exp_q.push_back(prev_code);
        prev_code = c;
        @(posedge clock);
        #1 start = 1'b0;
        repeat (10) @(posedge clock);
        // A start while busy must be ignored, so no extra word may appear.
        if (poke) begin
            #1 start = 1'b1;
            @(posedge clock);
            #1 start = 1'b0;
        end
        for (int k = 0; k < 80 && busy !== 1'b0; k++) begin
            @(posedge clock);
            #1;
        end
        check({15'h0, busy}, 16'h0);
        check({15'h0, convert_strobe_n}, 16'h1);
    endtask : read
    // Result watcher: takes the oldest note each time a word is handed up.
    always @(posedge clock) if (resetn === 1'b1 && result_valid === 1'b1) begin
        if (exp_q.size() == 0) check(result, ~result);
        else check(result, exp_q.pop_front());
    end
    // The negative clock pin follows the mode while a read runs.
    always @(negedge clock) if (busy === 1'b1)
        check({15'h0, shift_clk_neg}, (io_mode == MODE_CMOS) ? 16'h0 : {15'h0, ~shift_clk_pos});
    initial begin
        {resetn, start, io_mode, analog_code, prev_code} = '0;
        void'($urandom(91));
        repeat (5) @(posedge clock);
        #1 resetn = 1'b1;
        read(MODE_CMOS, 16'h7FFF, 1'b0);
        read(MODE_LVDS, 16'h8000, 1'b1);
        read(MODE_LPLVDS, 16'hFFFF, 1'b0);
        for (int i = 0; i < 6; i++) read(2'(i % 3), 16'($urandom), i[0]);
        repeat (5) @(posedge clock);
        check(16'(exp_q.size()), 16'h0);
        check(16'(model.viol), 16'h0);
        results();
    end
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
endmodule : test_sar_host
`default_nettype wire
